/* bench/rsc_props.sv */
// rsc_props.sv: port-level assertions for the reset source controller.
// assumes it is bound to rsc_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module rsc_props #(
  parameter int unsigned MASTER_CLEAR_PIN_CYC = 100,
  parameter int unsigned PPS_W    = 16
) (
  input wire logic             mclk_i,
  input wire logic             rst_n_i,
  input wire logic             avs_waitrequest_o,
  input wire logic             por_ok_i,
  input wire logic             bor_ok_i,
  input wire logic             master_clear_pin_n_i,
  input wire logic             reset_instr_i,
  input wire logic             wdt_timeout_i,
  input wire logic             sleep_idle_i,
  input wire logic             trap_req_i,
  input wire logic [3:0]       trap_lvl_i,
  input wire logic             trap_svc_i,
  input wire logic [3:0]       trap_svc_lvl_i,
  input wire logic [PPS_W-1:0] pps_ctrl_i,
  input wire logic [PPS_W-1:0] pps_shadow_i,
  input wire logic             opc_exec_i,
  input wire logic [23:0]      opc_word_i,
  input wire logic             wreg_ptr_i,
  input wire logic [3:0]       wreg_ptr_idx_i,
  input wire logic             system_reset_line_o,
  input wire logic             clk_reselect_o,
  input wire logic             wake_o,
  input wire logic [15:0]      wreg_init_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] low_cnt_r;
  // ==========================================================
  // consecutive low samples of the clear pin, saturating
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) low_cnt_r <= 8'h00;
    else if (master_clear_pin_n_i) low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'hFF) low_cnt_r <= low_cnt_r + 8'h01;
  end
  // ==========================================================
  // warm events act one edge after being taken
  a_swr_resets: assert property (reset_instr_i && !system_reset_line_o |=> system_reset_line_o)
    else $error("reset instruction ignored");
  a_swr_release: assert property ($rose(system_reset_line_o) && $past(reset_instr_i)
    |=> !system_reset_line_o) else $error("reset instruction held too long");
  a_wdt_resets: assert property (wdt_timeout_i && !sleep_idle_i && !system_reset_line_o
    |=> system_reset_line_o) else $error("watchdog ignored");
  a_wdt_wakes: assert property (wdt_timeout_i && sleep_idle_i && !system_reset_line_o
    |=> wake_o && !system_reset_line_o) else $error("watchdog in sleep misbehaved");
  a_trap_conflict: assert property (trap_req_i && trap_svc_i && trap_lvl_i >= 4'hD
    && trap_lvl_i < trap_svc_lvl_i && !system_reset_line_o |=> system_reset_line_o)
    else $error("trap conflict ignored");
  a_cfg_mismatch: assert property (pps_ctrl_i != pps_shadow_i && !system_reset_line_o
    |=> system_reset_line_o) else $error("mismatch ignored");
  a_illegal_opc: assert property (opc_exec_i && opc_word_i[23:16] == 8'h3F
    && !system_reset_line_o |=> system_reset_line_o) else $error("illegal opcode ignored");
  a_uninit_ptr: assert property (wreg_ptr_i && wreg_ptr_idx_i != 4'hF
    && !wreg_init_o[wreg_ptr_idx_i] && !system_reset_line_o |=> system_reset_line_o)
    else $error("uninitialised pointer ignored");
  a_brownout_hold: assert property (!bor_ok_i |=> system_reset_line_o)
    else $error("low supply without reset");
  a_clear_resets: assert property (low_cnt_r == MASTER_CLEAR_PIN_CYC + 1 |-> ##[1:2] system_reset_line_o)
    else $error("long clear pulse ignored");
  a_warm_clk_kept: assert property (por_ok_i && bor_ok_i && !clk_reselect_o
    |=> !clk_reselect_o) else $error("clock reselected on warm reset");
  a_release_idle: assert property ($fell(system_reset_line_o)
    |-> $past(bor_ok_i) && $past(master_clear_pin_n_i)) else $error("released early");
  a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
endmodule
bind rsc_top rsc_props #(.MASTER_CLEAR_PIN_CYC(MASTER_CLEAR_PIN_CYC), .PPS_W(PPS_W)) u_props (.mclk_i, .rst_n_i,
  .avs_waitrequest_o, .por_ok_i, .bor_ok_i, .master_clear_pin_n_i, .reset_instr_i,
  .wdt_timeout_i, .sleep_idle_i, .trap_req_i, .trap_lvl_i, .trap_svc_i, .trap_svc_lvl_i,
  .pps_ctrl_i, .pps_shadow_i, .opc_exec_i, .opc_word_i, .wreg_ptr_i, .wreg_ptr_idx_i,
  .system_reset_line_o, .clk_reselect_o, .wake_o, .wreg_init_o);
`default_nettype wire

/* bench/rsc_supervisor.sv */
// rsc_supervisor.sv: external supervisor driving the master clear pin.
// assumes callers of hold_low run in step with clk_i.
`timescale 1ns/1ps
`default_nettype none
module rsc_supervisor (
  input  wire logic clk_i,
  output var  logic pin_n_o
);
  // ==========================================================
  // pin has no pull-up, so it is always driven
  initial pin_n_o = 1'b1;
  task automatic hold_low(input int unsigned n);
    @(posedge clk_i);
    pin_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    pin_n_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* bench/rsc_tb_top.sv */
// rsc_tb_top.sv: self-checking bench for the reset source controller.
// assumes rsc_top, rsc_supervisor and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module rsc_tb_top;
  // ==========================================================
  // short counts keep the run brief; expectations use them
  localparam int TB = 6, TL = 10, PW = 4, TP = 5, MC = 4, OS = 8;
  typedef struct {int k; logic [31:0] c;} rsc_row_t;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [3:0] avs_byteenable_i = 4'hF, trap_lvl_i = 4'hD, trap_svc_lvl_i = 4'hE;
  logic [3:0] wreg_wr_idx_i = 4'h3, wreg_ptr_idx_i = 4'h3;
  logic por_ok_i = 1'b0, osc_tick_i = 1'b0, sleep_idle_i = 1'b0, bor_ok_i, trap_svc_i;
  logic reset_instr_i, wdt_timeout_i, trap_req_i, opc_exec_i, wreg_wr_i, wreg_ptr_i;
  logic flow_change_i, master_clear_pin_n_i, avs_waitrequest_o;
  logic system_reset_line_o, clk_reselect_o, wake_o;
  logic [15:0] pps_ctrl_i = 16'h00A5, pps_shadow_i, wreg_init_o;
  logic [23:0] opc_word_i = 24'h3F1234, flow_target_i = 24'h000200;
  int mismatches = 0, comparisons = 0, n;
  rsc_row_t rows[9] = '{'{0, 32'h0040}, '{1, 32'h0010}, '{2, 32'h8000}, '{3, 32'h0200},
    '{4, 32'h4000}, '{5, 32'h4000}, '{6, 32'h4000}, '{7, 32'h0080}, '{8, 32'h0002}};
  logic [31:0] cfgv[3] = '{32'h0040, 32'h0070, 32'h0043};
  int lo[3] = '{TB, TB + 2 * OS + TL, TB + 4 * PW};
  always #10 mclk_i = !mclk_i;
  always @(posedge mclk_i) osc_tick_i <= !osc_tick_i;
  rsc_top #(.BROWNOUT_EXTENSION_DELAY_CYC(TB), .PLL_LOCK_DELAY_CYC(TL), .PWRT_CYC(PW), .POWER_ON_EXTENSION_DELAY_CYC(TP), .MASTER_CLEAR_PIN_CYC(MC),
    .OST_CNT(OS), .PPS_W(16)) DUT (.mclk_i, .rst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .por_ok_i, .bor_ok_i, .osc_tick_i, .master_clear_pin_n_i, .reset_instr_i, .wdt_timeout_i,
    .sleep_idle_i, .trap_req_i, .trap_lvl_i, .trap_svc_i, .trap_svc_lvl_i, .pps_ctrl_i,
    .pps_shadow_i, .opc_exec_i, .opc_word_i, .wreg_wr_i, .wreg_wr_idx_i, .wreg_ptr_i,
    .wreg_ptr_idx_i, .flow_change_i, .flow_target_i, .system_reset_line_o, .clk_reselect_o,
    .wake_o, .wreg_init_o);
  rsc_supervisor sup (.clk_i(mclk_i), .pin_n_o(master_clear_pin_n_i));
  // ==========================================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic fail(input string nm);
    mismatches++;
    $display("MISMATCH %s expected done seen timeout", nm);
    conclude();
  endtask
  // ==========================================================
  // bus cycle: request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge mclk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (k >= 20) fail("bus");
  endtask
  task automatic wait_line(input logic v, output int k);
    k = 0;
    while (system_reset_line_o !== v && k < 5000) begin
      @(posedge mclk_i);
      k++;
    end
    if (k >= 5000) fail("reset line");
  endtask
  task automatic high_for(input int c, output int h);
    h = 0;
    repeat (c) begin
      @(posedge mclk_i);
      h += int'(system_reset_line_o !== 1'b0);
    end
  endtask
  task automatic idle();
    reset_instr_i <= 1'b0;
    wdt_timeout_i <= 1'b0;
    trap_req_i <= 1'b0;
    trap_svc_i <= 1'b0;
    pps_shadow_i <= 16'h00A5;
    opc_exec_i <= 1'b0;
    wreg_wr_i <= 1'b0;
    wreg_ptr_i <= 1'b0;
    flow_change_i <= 1'b0;
    bor_ok_i <= 1'b1;
  endtask
  task automatic fire(input int k);
    @(posedge mclk_i);
    case (k)
      0: reset_instr_i <= 1'b1;
      1: wdt_timeout_i <= 1'b1;
      2: begin
        trap_req_i <= 1'b1;
        trap_svc_i <= 1'b1;
      end
      3: pps_shadow_i <= 16'h00A4;
      4: opc_exec_i <= 1'b1;
      5: wreg_ptr_i <= 1'b1;
      6: flow_change_i <= 1'b1;
      7: sup.hold_low(MC + 3);
      9: wreg_wr_i <= 1'b1;
      default: bor_ok_i <= 1'b0;
    endcase
    @(posedge mclk_i);
    idle();
  endtask
  // ==========================================================
  // main sequence
  initial begin
    idle();
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    por_ok_i <= 1'b1;
    wait_line(1'b0, n);
    chk("power-up hold", 32'h1, 32'(n >= TP + TB + 64 * PW));
    chk("wreg init", 32'h8000, {16'h0000, wreg_init_o});
    bus(1'b0, 8'h00, 32'h0);
    chk("cold cause", 32'h0003, q);
    bus(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h0, q);
    foreach (rows[i]) begin
      bus(1'b1, 8'h00, 32'h0);
      fire(rows[i].k);
      wait_line(1'b1, n);
      wait_line(1'b0, n);
      if (i == 0) chk("swr length", 32'h1, 32'(n));
      if (i < 8) chk("warm clock", 32'h0, {31'h0, clk_reselect_o});
      bus(1'b0, 8'h00, 32'h0);
      chk("cause", rows[i].c, q);
    end
    sleep_idle_i <= 1'b1;
    fire(1);
    @(posedge mclk_i);
    chk("wake", 32'h1, {31'h0, wake_o});
    chk("sleep line", 32'h0, {31'h0, system_reset_line_o});
    sleep_idle_i <= 1'b0;
    sup.hold_low(MC);
    high_for(8, n);
    chk("short clear", 32'h0, 32'(n));
    bus(1'b1, 8'h00, 32'h0000FFFF);
    high_for(4, n);
    chk("flag write", 32'h0, 32'(n));
    bus(1'b0, 8'h00, 32'h0);
    chk("flag mask", 32'h0000C2D3, q);
    fire(9);
    fire(5);
    high_for(4, n);
    chk("written ptr", 32'h0, 32'(n));
    chk("init bit", 32'h8008, {16'h0000, wreg_init_o});
    // crystal and lock delays only add, so a floor is checked
    foreach (cfgv[i]) begin
      bus(1'b1, 8'h04, cfgv[i]);
      fire(8);
      wait_line(1'b1, n);
      wait_line(1'b0, n);
      chk("cold hold", 32'h1, 32'(n >= lo[i]));
    end
    conclude();
  end
endmodule
`default_nettype wire

/* verilog/rsc_cfg.svh */
// rsc_cfg.svh: offsets, field positions, reset values and timing counts
// for the reset source controller; assumes a 50 MHz system clock.
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// ==========================================================
// register map (byte addresses)
`define RSC_ADDR_CAUSE   8'h00
`define RSC_ADDR_CFG     8'h04
`define RSC_ADDR_STAT    8'h08

// ==========================================================
// reset cause register bits
`define RSC_B_POR        0
`define RSC_B_BOR        1
`define RSC_B_WATCHDOG_TIMEOUT_FLAG       4
`define RSC_B_SWR        6
`define RSC_B_EXTERNAL_RESET_FLAG       7
`define RSC_B_CM         9
`define RSC_B_ILL        14
`define RSC_B_TRAP       15
`define RSC_CAUSE_MASK   16'hC2D3
`define RSC_CAUSE_COLD   16'h0003

// ==========================================================
// config register fields and reset value
`define RSC_CFG_XTAL     4
`define RSC_CFG_PLL      5
`define RSC_CFG_SECEN    6
`define RSC_CFG_RST      8'h47

// ==========================================================
// timing
`define RSC_CLK_MHZ      50
`define RSC_POWER_ON_EXTENSION_DELAY_NS      30000
`define RSC_BROWNOUT_EXTENSION_DELAY_NS      100000
`define RSC_PLL_LOCK_DELAY_US     1500
`define RSC_PWRT_UNIT_MS 2
`define RSC_MASTER_CLEAR_PIN_MIN_NS  2000
`define RSC_OST_PERIODS  1024
`define RSC_POWER_ON_EXTENSION_DELAY_CYC     ((`RSC_POWER_ON_EXTENSION_DELAY_NS * `RSC_CLK_MHZ) / 1000)
`define RSC_BROWNOUT_EXTENSION_DELAY_CYC     ((`RSC_BROWNOUT_EXTENSION_DELAY_NS * `RSC_CLK_MHZ) / 1000)
`define RSC_PLL_LOCK_DELAY_CYC    (`RSC_PLL_LOCK_DELAY_US * `RSC_CLK_MHZ)
`define RSC_PWRT_CYC     (`RSC_PWRT_UNIT_MS * 1000 * `RSC_CLK_MHZ)
`define RSC_MASTER_CLEAR_PIN_CYC     ((`RSC_MASTER_CLEAR_PIN_MIN_NS * `RSC_CLK_MHZ) / 1000)

// ==========================================================
// hard traps, illegal opcode, protected segment
`define RSC_HARD_LO      4'hD
`define RSC_HARD_HI      4'hF
`define RSC_ILL_OPC      8'h3F
`define RSC_SEC_LO       24'h000200
`define RSC_SEC_HI       24'h0003FF
`define RSC_SP_IDX       4'hF

`endif

/* verilog/rsc_pkg.sv */
// rsc_pkg.sv: types shared by the reset source controller.
// assumes rsc_cfg.svh is on the include path.
package rsc_pkg;

  // ==========================================================
  // power sequencer states
  typedef enum logic [5:0] {
    RSC_ST_POR  = 6'b000001,
    RSC_ST_BOR  = 6'b000010,
    RSC_ST_PWRT = 6'b000100,
    RSC_ST_OST  = 6'b001000,
    RSC_ST_LOCK = 6'b010000,
    RSC_ST_RUN  = 6'b100000
  } rsc_state_t;

  // ==========================================================
  // warm reset events of one cycle
  typedef struct packed {
    logic trap;
    logic ill;
    logic cm;
    logic software_reset_flag;
    logic watchdog_timeout_flag;
  } rsc_evt_t;

endpackage

/* verilog/rsc_top.sv */
// rsc_top.sv: reset source controller, Avalon-MM slave with waitrequest.
// assumes all inputs synchronous to mclk_i; rst_n_i is the power event.
//
// Functional notes
// RQ1: crystal mode holds reset 1024 oscillator periods
// RQ2: PLL mode adds lock delay to hold
// RQ3: POR holds until supply good plus extension
// RQ4: power-on reset sets cause bit 0
// RQ5: low supply resets until good plus extension
// RQ6: brown-out reset sets cause bit 1
// RQ7: three-bit select picks power-up delay
// RQ8: brown-out plus power-up delay restarts on rise
// RQ9: master clear low, glitch filtered, resets
// RQ10: master clear reset sets external flag
// RQ11: reset instruction: reset one cycle, clock kept
// RQ12: software reset sets cause bit 6
// RQ13: watchdog time-out resets while running
// RQ14: watchdog in sleep or idle only wakes
// RQ15: watchdog reset sets cause bit 4
// RQ16: lower hard trap during higher trap resets
// RQ17: trap conflict sets cause bit 15
// RQ18: pin-select shadow mismatch resets, sets bit 9; sets bit 8 instead when a cause write lands in the same cycle
// RQ19: illegal conditions reset and set bit 14
// RQ20: opcode upper byte 3Fh is illegal
// RQ21: working registers uninitialised after reset
// RQ22: flow change into protected segment resets
// RQ23: warm resets keep current clock source
// RQ24: software sets or clears flags, no reset
// RQ25: system reset is OR of all sources
`include "rsc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rsc_top
  import rsc_pkg::*;
#(
  parameter int unsigned BROWNOUT_EXTENSION_DELAY_CYC  = `RSC_BROWNOUT_EXTENSION_DELAY_CYC,
  parameter int unsigned PLL_LOCK_DELAY_CYC = `RSC_PLL_LOCK_DELAY_CYC,
  parameter int unsigned PWRT_CYC  = `RSC_PWRT_CYC,
  parameter int unsigned POWER_ON_EXTENSION_DELAY_CYC  = `RSC_POWER_ON_EXTENSION_DELAY_CYC,
  parameter int unsigned MASTER_CLEAR_PIN_CYC  = `RSC_MASTER_CLEAR_PIN_CYC,
  parameter int unsigned OST_CNT   = `RSC_OST_PERIODS,
  parameter int unsigned PPS_W     = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic [7:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  input  wire logic             por_ok_i,
  input  wire logic             bor_ok_i,
  input  wire logic             osc_tick_i,
  input  wire logic             master_clear_pin_n_i,
  input  wire logic             reset_instr_i,
  input  wire logic             wdt_timeout_i,
  input  wire logic             sleep_idle_i,
  input  wire logic             trap_req_i,
  input  wire logic [3:0]       trap_lvl_i,
  input  wire logic             trap_svc_i,
  input  wire logic [3:0]       trap_svc_lvl_i,
  input  wire logic [PPS_W-1:0] pps_ctrl_i,
  input  wire logic [PPS_W-1:0] pps_shadow_i,
  input  wire logic             opc_exec_i,
  input  wire logic [23:0]      opc_word_i,
  input  wire logic             wreg_wr_i,
  input  wire logic [3:0]       wreg_wr_idx_i,
  input  wire logic             wreg_ptr_i,
  input  wire logic [3:0]       wreg_ptr_idx_i,
  input  wire logic             flow_change_i,
  input  wire logic [23:0]      flow_target_i,
  output logic                  system_reset_line_o,
  output logic                  clk_reselect_o,
  output logic                  wake_o,
  output logic      [15:0]      wreg_init_o
);

  // ==========================================================
  // reset release
  logic       rst_s1_r;
  logic       rst_n_r;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ==========================================================
  // declarations
  rsc_state_t  state_r;
  rsc_state_t  state_nxt;
  logic [31:0] tmr_r;
  logic [31:0] tmr_nxt;
  logic [31:0] pwrt_cyc;
  logic [15:0] cause_r;
  logic [7:0]  cfg_r;
  logic [15:0] master_clear_pin_cnt_r;
  logic        master_clear_pin_act_r;
  logic        osc_prev_r;
  logic        sys_rst_r;
  logic        live;
  logic        cold;
  logic        bor_hit;
  rsc_evt_t    evt;
  logic        evt_any;
  logic        acc;
  logic        wr_hit;
  logic [15:0] be_mask;
  logic [31:0] rd_data;

  // ==========================================================
  // power sequencer
  // 0 ms, then 2 ms doubling up to 128 ms
  assign pwrt_cyc = (cfg_r[2:0] == 3'h0) ? 32'h0 :
                    (PWRT_CYC << (cfg_r[2:0] - 3'h1)); // RQ7

  always_comb begin
    state_nxt = state_r;
    tmr_nxt   = (tmr_r != 32'h0) ? tmr_r - 32'h1 : 32'h0;
    unique case (state_r)
      RSC_ST_POR: begin
        if (!por_ok_i) begin
          tmr_nxt = POWER_ON_EXTENSION_DELAY_CYC; // RQ3
        end else if (tmr_r == 32'h0) begin
          state_nxt = RSC_ST_BOR;
          tmr_nxt   = BROWNOUT_EXTENSION_DELAY_CYC;
        end
      end
      RSC_ST_BOR: begin
        if (tmr_r == 32'h0) begin
          state_nxt = RSC_ST_PWRT;
          tmr_nxt   = pwrt_cyc; // RQ7
        end
      end
      RSC_ST_PWRT: begin
        if (tmr_r == 32'h0) begin
          state_nxt = RSC_ST_OST;
          tmr_nxt   = cfg_r[`RSC_CFG_XTAL] ? OST_CNT : 32'h0;
        end
      end
      RSC_ST_OST: begin
        // counts oscillator edges, not system clocks
        tmr_nxt = tmr_r;
        if (osc_tick_i && !osc_prev_r && tmr_r != 32'h0) begin
          tmr_nxt = tmr_r - 32'h1; // RQ1
        end
        if (tmr_r == 32'h0) begin
          state_nxt = RSC_ST_LOCK;
          tmr_nxt   = cfg_r[`RSC_CFG_PLL] ? PLL_LOCK_DELAY_CYC : 32'h0; // RQ2
        end
      end
      RSC_ST_LOCK: begin
        if (tmr_r == 32'h0) begin
          state_nxt = RSC_ST_RUN;
        end
      end
      RSC_ST_RUN: begin
        tmr_nxt = 32'h0;
      end
    endcase
    // low supply restarts the chain from the brown-out extension
    if (!bor_ok_i && state_r != RSC_ST_POR) begin
      state_nxt = RSC_ST_BOR; // RQ5
      tmr_nxt   = BROWNOUT_EXTENSION_DELAY_CYC; // RQ8
    end
    if (!por_ok_i) begin
      state_nxt = RSC_ST_POR;
      tmr_nxt   = POWER_ON_EXTENSION_DELAY_CYC;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= RSC_ST_POR;
      tmr_r   <= 32'h0;
    end else begin
      state_r <= state_nxt;
      tmr_r   <= tmr_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_tick_i;
    end
  end

  assign cold    = (state_r != RSC_ST_RUN);
  assign bor_hit = !bor_ok_i && por_ok_i && (state_r != RSC_ST_POR)
                   && (state_r != RSC_ST_BOR);

  // ==========================================================
  // master clear glitch filter
  // pulses of up to MASTER_CLEAR_PIN_CYC clocks are ignored
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      master_clear_pin_cnt_r <= 16'h0;
      master_clear_pin_act_r <= 1'b0;
    end else if (master_clear_pin_n_i) begin
      master_clear_pin_cnt_r <= 16'h0;
      master_clear_pin_act_r <= 1'b0;
    end else if (master_clear_pin_cnt_r == MASTER_CLEAR_PIN_CYC[15:0]) begin
      master_clear_pin_act_r <= 1'b1; // RQ9
    end else begin
      master_clear_pin_cnt_r <= master_clear_pin_cnt_r + 16'h1;
    end
  end

  // ==========================================================
  // warm reset events
  // the core is held while sys_rst_r is high, so its strobes are masked
  assign live      = !cold && !sys_rst_r;
  assign evt.software_reset_flag   = live && reset_instr_i;
  assign evt.watchdog_timeout_flag  = live && wdt_timeout_i && !sleep_idle_i; // RQ13
  assign evt.trap  = live && trap_req_i && trap_svc_i
                     && trap_lvl_i >= `RSC_HARD_LO && trap_lvl_i <= `RSC_HARD_HI
                     && trap_svc_lvl_i > trap_lvl_i; // RQ16
  assign evt.cm    = live && (pps_ctrl_i != pps_shadow_i); // RQ18
  assign evt.ill   = live && ((opc_exec_i && opc_word_i[23:16] == `RSC_ILL_OPC) // RQ20
                     || (wreg_ptr_i && !wreg_init_o[wreg_ptr_idx_i]) // RQ21
                     || (flow_change_i && cfg_r[`RSC_CFG_SECEN]
                         && flow_target_i >= `RSC_SEC_LO
                         && flow_target_i <= `RSC_SEC_HI)); // RQ22
  assign evt_any   = |evt; // RQ19

  // ==========================================================
  // system reset line
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sys_rst_r           <= 1'b1;
      system_reset_line_o <= 1'b1;
    end else begin
      // a warm event holds reset for exactly one cycle
      sys_rst_r           <= (state_nxt != RSC_ST_RUN) || master_clear_pin_act_r || evt_any; // RQ25
      system_reset_line_o <= (state_nxt != RSC_ST_RUN) || master_clear_pin_act_r || evt_any; // RQ11
    end
  end

  // only cold sequences reselect the clock source
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      clk_reselect_o <= 1'b1;
    end else begin
      clk_reselect_o <= (state_nxt == RSC_ST_POR) || (state_nxt == RSC_ST_BOR); // RQ23
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= live && wdt_timeout_i && sleep_idle_i; // RQ14
    end
  end

  // ==========================================================
  // working register init tracking
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_wreg
      always_ff @(posedge mclk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
          wreg_init_o[gi] <= (gi == `RSC_SP_IDX);
        end else if (system_reset_line_o) begin
          wreg_init_o[gi] <= (gi == `RSC_SP_IDX); // RQ21
        end else if (wreg_wr_i && wreg_wr_idx_i == gi) begin
          wreg_init_o[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Avalon-MM slave
  // one wait cycle on every access, then one cycle with waitrequest low
  assign acc     = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
  assign wr_hit  = acc && avs_write_i;
  assign be_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  always_comb begin
    rd_data = 32'h0;
    unique case (avs_address_i)
      `RSC_ADDR_CAUSE: rd_data = {16'h0, cause_r};
      `RSC_ADDR_CFG:   rd_data = {24'h0, cfg_r};
      `RSC_ADDR_STAT:  rd_data = {wreg_init_o, 8'h0, 1'b0, sys_rst_r,
                                  state_r};
      default:         rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        avs_readdata_o <= rd_data;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cfg_r <= `RSC_CFG_RST;
    end else if (wr_hit && avs_address_i == `RSC_ADDR_CFG && avs_byteenable_i[0]) begin
      cfg_r <= avs_writedata_i[7:0];
    end
  end

  // ==========================================================
  // reset cause register
  // hardware set wins over a software clear in the same cycle, but evt.cm then sets bit 8, not bit 9
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cause_r <= `RSC_CAUSE_COLD; // RQ4
    end else if (!por_ok_i) begin
      cause_r <= `RSC_CAUSE_COLD; // RQ4
    end else begin
      if (bor_hit) begin
        // brown-out keeps only the external flag; beats a software write
        cause_r <= (cause_r & (16'h1 << `RSC_B_EXTERNAL_RESET_FLAG))
                   | (16'h1 << `RSC_B_BOR); // RQ6
      end else if (wr_hit && avs_address_i == `RSC_ADDR_CAUSE) begin
        cause_r <= ((cause_r & ~be_mask) | (avs_writedata_i[15:0] & be_mask)
                   & `RSC_CAUSE_MASK) | {evt.trap, evt.ill, 5'h0, evt.cm,
                   master_clear_pin_act_r, evt.software_reset_flag, 1'b0, evt.watchdog_timeout_flag, 4'h0}; // RQ24
      end else begin
        if (evt.trap) cause_r[`RSC_B_TRAP] <= 1'b1; // RQ17
        if (evt.ill)  cause_r[`RSC_B_ILL]  <= 1'b1; // RQ19
        if (evt.cm)   cause_r[`RSC_B_CM]   <= 1'b1; // RQ18
        if (master_clear_pin_act_r) cause_r[`RSC_B_EXTERNAL_RESET_FLAG] <= 1'b1; // RQ10
        if (evt.software_reset_flag)  cause_r[`RSC_B_SWR]  <= 1'b1; // RQ12
        if (evt.watchdog_timeout_flag) cause_r[`RSC_B_WATCHDOG_TIMEOUT_FLAG] <= 1'b1; // RQ15
      end
    end
  end

endmodule

`default_nettype wire
